/* File: tspg_pkg.sv */
package tspg_pkg;
    localparam int NUM_CH     = 5;
    localparam int CNT_W      = 16;
    localparam int BYTE_W     = 8;
    localparam int STATE_W    = 2;
    localparam int MODE_W     = 2;
    localparam int ADDR_W     = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    // bus cycle states; the capture event contends with a write in BUS_T3
    localparam logic [STATE_W-1:0] BUS_T1 = 2'h1;
    localparam logic [STATE_W-1:0] BUS_T2 = 2'h2;
    localparam logic [STATE_W-1:0] BUS_T3 = 2'h3;

    // combined mode encodings {high bit, low bit}
    localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h0;
    localparam logic [MODE_W-1:0] MODE_COMPL  = 2'h2;
    localparam logic [MODE_W-1:0] MODE_RSYNC  = 2'h3;
    localparam int MODE_HI_POS = 1;
    localparam int CH_THREE    = 3;
    localparam int CH_FOUR     = 4;

    // target select for a processor write
    localparam logic [ADDR_W-1:0] SEL_CNT0 = 4'h0;
    localparam logic [ADDR_W-1:0] SEL_BUF0 = 4'h5;
    localparam logic [ADDR_W-1:0] SEL_MODE = 4'hA;

    typedef struct packed {
        logic                 wr;
        logic [STATE_W-1:0]   state;
        logic [ADDR_W-1:0]    sel;
        logic                 hi_en;
        logic                 lo_en;
        logic [CNT_W-1:0]     data;
    } tspg_wr_t;
endpackage

/* File: tspg_guard.sv */
module tspg_guard
    import tspg_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire tspg_wr_t             bus_wr,
    input  wire logic [NUM_CH-1:0]    channel_sync_select,
    input  wire logic [NUM_CH-1:0]    cnt_run,
    input  wire logic [NUM_CH-1:0]    capture_evt,
    input  wire logic [NUM_CH-1:0]    buf_capture_mode,
    input  wire logic [CNT_W-1:0]     capture_val [NUM_CH],
    output logic [CNT_W-1:0]          channel_count_value [NUM_CH],
    output logic [CNT_W-1:0]          buf_value [NUM_CH],
    output logic                      combined_mode_high_bit,
    output logic                      combined_mode_low_bit,
    output logic                      mode_write_flagged
);
    logic [CNT_W-1:0] cnt_ff [NUM_CH];
    logic [CNT_W-1:0] buf_ff [NUM_CH];
    logic [MODE_W-1:0] mode_ff;
    logic              flag_ff;
    logic              wr_t3;
    logic              cnt_hit;
    logic [ADDR_W-1:0] cnt_idx;
    logic [CNT_W-1:0]  nxt_preset;
    logic [NUM_CH-1:0] cnt_load;

    assign wr_t3   = bus_wr.wr && (bus_wr.state == BUS_T3);
    assign cnt_idx = bus_wr.sel - SEL_CNT0;
    assign cnt_hit = wr_t3 && (bus_wr.sel < SEL_CNT0 + ADDR_W'(NUM_CH));

    // merge written bytes over the addressed counter's retained bytes
    always_comb begin
        nxt_preset = CNT_RST;
        cnt_load   = '0;
        if (cnt_hit) begin
            nxt_preset = cnt_ff[cnt_idx[2:0]];
            if (bus_wr.hi_en)
                nxt_preset[CNT_W-1:BYTE_W] = bus_wr.data[CNT_W-1:BYTE_W];
            if (bus_wr.lo_en)
                nxt_preset[BYTE_W-1:0] = bus_wr.data[BYTE_W-1:0];
            cnt_load[cnt_idx[2:0]] = 1'b1;
            if (channel_sync_select[cnt_idx[2:0]])
                cnt_load = cnt_load | channel_sync_select;
        end
    end

    // one edge updates every member of the group
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_CH; i++)
                cnt_ff[i] <= CNT_RST;
        end else begin
            for (int i = 0; i < NUM_CH; i++)
                if (cnt_load[i])
                    cnt_ff[i] <= nxt_preset;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_CH; i++)
                buf_ff[i] <= CNT_RST;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (buf_capture_mode[i] && capture_evt[i])
                    buf_ff[i] <= capture_val[i];
                else if (wr_t3 && bus_wr.sel == SEL_BUF0 + ADDR_W'(i)) begin
                    if (bus_wr.hi_en)
                        buf_ff[i][CNT_W-1:BYTE_W] <=
                            bus_wr.data[CNT_W-1:BYTE_W];
                    if (bus_wr.lo_en)
                        buf_ff[i][BYTE_W-1:0] <= bus_wr.data[BYTE_W-1:0];
                end
            end
        end
    end

    // mode field stored as written; misuse is only flagged
    logic mode_wr;
    logic bad_run;
    logic bad_jump;
    assign mode_wr  = wr_t3 && bus_wr.sel == SEL_MODE && bus_wr.lo_en;
    assign bad_run  = cnt_run[CH_THREE] || cnt_run[CH_FOUR];
    assign bad_jump = mode_ff[MODE_HI_POS]
                   && bus_wr.data[MODE_HI_POS]
                   && mode_ff != bus_wr.data[MODE_W-1:0];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            mode_ff <= MODE_NORMAL;
        else if (mode_wr)
            mode_ff <= bus_wr.data[MODE_W-1:0];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            flag_ff <= 1'b0;
        else if (mode_wr)
            flag_ff <= bad_run || bad_jump;
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            channel_count_value[i] = cnt_ff[i];
            buf_value[i]           = buf_ff[i];
        end
    end
    assign combined_mode_high_bit = mode_ff[1];
    assign combined_mode_low_bit  = mode_ff[0];
    assign mode_write_flagged     = flag_ff;

    a_capture_beats_write: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (buf_capture_mode[0] && capture_evt[0] && wr_t3
         && bus_wr.sel == SEL_BUF0)
        |=> buf_ff[0] == $past(capture_val[0]))
        else $error("buffer write beat capture");

    a_sync_word_copy: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (cnt_hit && bus_wr.hi_en && bus_wr.lo_en && cnt_idx == 4'h2
         && channel_sync_select[2] && channel_sync_select[3])
        |=> cnt_ff[3] == $past(bus_wr.data) && cnt_ff[2] == cnt_ff[3])
        else $error("word preset not copied");

    a_sync_byte_keep: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (cnt_hit && bus_wr.hi_en && !bus_wr.lo_en && cnt_idx == 4'h2
         && channel_sync_select[3] && channel_sync_select[2])
        |=> cnt_ff[3][BYTE_W-1:0] == $past(cnt_ff[2][BYTE_W-1:0]))
        else $error("retained byte not taken from addressed counter");

    a_sync_byte_load: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (cnt_hit && !bus_wr.hi_en && bus_wr.lo_en && cnt_idx == 4'h3
         && channel_sync_select[2] && channel_sync_select[3])
        |=> cnt_ff[2][BYTE_W-1:0] == $past(bus_wr.data[BYTE_W-1:0]))
        else $error("byte preset missed a synced counter");

    a_group_same_cycle: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (cnt_hit && channel_sync_select[cnt_idx[2:0]]
         && channel_sync_select[0])
        |=> cnt_ff[0] == cnt_ff[cnt_idx[2:0]])
        else $error("group preset not simultaneous");

    a_mode_run_flag: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (mode_wr && bad_run) |=> flag_ff)
        else $error("running mode change not flagged");

    a_mode_jump_flag: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (mode_wr && mode_ff == MODE_RSYNC
         && bus_wr.data[MODE_W-1:0] == MODE_COMPL) |=> flag_ff)
        else $error("direct pwm switch not flagged");

    a_mode_clean_write: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (mode_wr && !bad_run && !bus_wr.data[MODE_HI_POS])
        |=> !flag_ff && !combined_mode_high_bit)
        else $error("return to normal mishandled");

    a_unsync_hold: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (cnt_hit && !channel_sync_select[cnt_idx[2:0]] && cnt_idx != 4'h3)
        |=> cnt_ff[3] == $past(cnt_ff[3]))
        else $error("unsynced write touched another counter");

    a_capture_always_wins: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (buf_capture_mode[0] && capture_evt[0])
        |=> buf_value[0] == $past(capture_val[0]))
        else $error("capture not stored in buffer");

    a_buf_write_lands: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr_t3 && bus_wr.sel == SEL_BUF0 && bus_wr.hi_en && bus_wr.lo_en
         && !(buf_capture_mode[0] && capture_evt[0]))
        |=> buf_ff[0] == $past(bus_wr.data))
        else $error("buffer word write lost");

    a_mode_stored: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        mode_wr |=> {combined_mode_high_bit, combined_mode_low_bit}
                    == $past(bus_wr.data[MODE_W-1:0]))
        else $error("mode field not stored as written");

    a_jump_back_flag: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (mode_wr && mode_ff == MODE_COMPL
         && bus_wr.data[MODE_W-1:0] == MODE_RSYNC) |=> flag_ff)
        else $error("direct pwm switch back not flagged");

    c_sync_word: cover property (@(posedge core_clk) disable iff (!reset_n)
        cnt_hit && bus_wr.hi_en && bus_wr.lo_en && channel_sync_select[2]);
    c_sync_byte: cover property (@(posedge core_clk) disable iff (!reset_n)
        cnt_hit && (bus_wr.hi_en != bus_wr.lo_en) && channel_sync_select[3]);
    c_capture_clash: cover property (@(posedge core_clk)
        disable iff (!reset_n)
        wr_t3 && bus_wr.sel == SEL_BUF0 && capture_evt[0]
        && buf_capture_mode[0]);
    c_mode_flag: cover property (@(posedge core_clk) disable iff (!reset_n)
        mode_wr ##1 flag_ff);
    c_mode_jump: cover property (@(posedge core_clk) disable iff (!reset_n)
        mode_wr && bad_jump);
endmodule

/* File: tspg_cpu_model.sv */
module tspg_cpu_model
    import tspg_pkg::*;
(
    input  wire logic     core_clk,
    input  wire logic     reset_n,
    input  wire tspg_wr_t req,
    input  wire logic     go,
    output tspg_wr_t      bus_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    // walks one write through T1, T2, T3, then releases the bus
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            bus_wr <= '0;
        else if (go)
            bus_wr <= '{1'b1, BUS_T1, req.sel, req.hi_en, req.lo_en, req.data};
        else if (bus_wr.wr && bus_wr.state != BUS_T3)
            bus_wr.state <= bus_wr.state + 2'h1;
        else begin
            // released: the data lines invert their last value on every idle cycle until the next write
            bus_wr.wr    <= 1'b0;
            bus_wr.state <= 2'h0;
            bus_wr.data  <= ~bus_wr.data;
        end
    end
endmodule

/* File: tb_top.sv */
module tb_top
    import tspg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0]  sync;
        logic [3:0]  sel;
        logic        hi;
        logic        lo;
        logic [15:0] d;
        logic [15:0] e2;
        logic [15:0] e3;
    } tspg_row_t;
    logic                    core_clk = 1'b0;
    logic                    reset_n;
    logic                    go;
    tspg_wr_t                req;
    tspg_wr_t                bus_wr;
    logic [NUM_CH-1:0]       channel_sync_select;
    logic [NUM_CH-1:0]       cnt_run;
    logic [NUM_CH-1:0]       capture_evt;
    logic [NUM_CH-1:0]       buf_capture_mode;
    logic [CNT_W-1:0]        capture_val [NUM_CH];
    logic [CNT_W-1:0]        channel_count_value [NUM_CH];
    logic [CNT_W-1:0]        buf_value [NUM_CH];
    logic                    combined_mode_high_bit;
    logic                    combined_mode_low_bit;
    logic                    mode_write_flagged;
    int                      n_mismatch = 0;
    int                      n_tests = 0;
    int                      cyc = 0;
    logic [MODE_W-1:0]       modes [4] = '{MODE_RSYNC, MODE_NORMAL,
                                           MODE_COMPL, MODE_NORMAL};
    tspg_row_t               rows [6] = '{
        '{5'h0C, 4'h2, 1'b1, 1'b1, 16'h1234, 16'h1234, 16'h1234},
        '{5'h00, 4'h3, 1'b1, 1'b1, 16'h5678, 16'h1234, 16'h5678},
        '{5'h0C, 4'h2, 1'b1, 1'b0, 16'hA0FF, 16'hA034, 16'hA034},
        '{5'h00, 4'h2, 1'b1, 1'b1, 16'hBB11, 16'hBB11, 16'hA034},
        '{5'h0C, 4'h3, 1'b0, 1'b1, 16'hFFC5, 16'hA0C5, 16'hA0C5},
        '{5'h05, 4'h0, 1'b1, 1'b1, 16'hC3C3, 16'hC3C3, 16'hA0C5}};

    tspg_cpu_model cpu_u (.core_clk, .reset_n, .req, .go, .bus_wr);
    tspg_guard dut_u (.core_clk, .reset_n, .bus_wr, .channel_sync_select,
        .cnt_run, .capture_evt, .buf_capture_mode, .capture_val,
        .channel_count_value, .buf_value, .combined_mode_high_bit,
        .combined_mode_low_bit, .mode_write_flagged);

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    // capture pulse lands on the T3 edge when cap is set
    task automatic write_cyc(logic [3:0] sel, logic hi, logic lo,
                             logic [15:0] d, logic [4:0] cap);
        @(posedge core_clk);
        req <= '{1'b1, BUS_T1, sel, hi, lo, d};
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (2) @(posedge core_clk);
        capture_evt <= cap;
        @(posedge core_clk);
        capture_evt <= '0;
        @(negedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        reset_n = 1'b0;
        go = 1'b0;
        req = '0;
        channel_sync_select = '0;
        cnt_run = '0;
        capture_evt = '0;
        buf_capture_mode = '0;
        foreach (capture_val[i]) capture_val[i] = 16'h4242;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        chk("count2", CNT_RST, channel_count_value[2]);
        chk("mode", 16'h0000, {14'h0, combined_mode_high_bit,
            combined_mode_low_bit});
        foreach (rows[i]) begin
            @(posedge core_clk);
            channel_sync_select <= rows[i].sync;
            write_cyc(rows[i].sel, rows[i].hi, rows[i].lo, rows[i].d, '0);
            chk("count2", rows[i].e2, channel_count_value[2]);
            chk("count3", rows[i].e3, channel_count_value[3]);
        end
        chk("count0", 16'hC3C3, channel_count_value[0]);
        chk("count4", CNT_RST, channel_count_value[4]);
        @(posedge core_clk);
        buf_capture_mode <= 5'h01;
        write_cyc(SEL_BUF0, 1'b1, 1'b1, 16'h9999, 5'h01);
        chk("buf0", 16'h4242, buf_value[0]);
        write_cyc(SEL_BUF0, 1'b1, 1'b1, 16'h9999, 5'h00);
        chk("buf0", 16'h9999, buf_value[0]);
        foreach (modes[i]) begin
            write_cyc(SEL_MODE, 1'b0, 1'b1, {14'h0, modes[i]}, '0);
            chk("mode", {14'h0, modes[i]}, {14'h0, combined_mode_high_bit,
                combined_mode_low_bit});
            chk("flag", 16'h0000, {15'h0, mode_write_flagged});
        end
        @(posedge core_clk);
        cnt_run <= 5'h18;
        write_cyc(SEL_MODE, 1'b0, 1'b1, {14'h0, MODE_RSYNC}, '0);
        chk("flag", 16'h0001, {15'h0, mode_write_flagged});
        @(posedge core_clk);
        cnt_run <= '0;
        write_cyc(SEL_MODE, 1'b0, 1'b1, {14'h0, MODE_COMPL}, '0);
        chk("flag", 16'h0001, {15'h0, mode_write_flagged});
        write_cyc(SEL_MODE, 1'b0, 1'b1, {14'h0, MODE_RSYNC}, '0);
        chk("flag", 16'h0001, {15'h0, mode_write_flagged});
        write_cyc(SEL_MODE, 1'b0, 1'b1, {14'h0, MODE_NORMAL}, '0);
        chk("flag", 16'h0000, {15'h0, mode_write_flagged});
        chk("hibit", 16'h0000, {15'h0, combined_mode_high_bit});
        write_cyc(SEL_MODE, 1'b0, 1'b1, {14'h0, MODE_COMPL}, '0);
        chk("flag", 16'h0000, {15'h0, mode_write_flagged});
        // second reset in mid-run clears counters, buffers and mode
        @(posedge core_clk);
        reset_n <= 1'b0;
        @(negedge core_clk);
        chk("count0", CNT_RST, channel_count_value[0]);
        chk("buf0", CNT_RST, buf_value[0]);
        chk("mode", 16'h0000, {14'h0, combined_mode_high_bit,
            combined_mode_low_bit});
        @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        write_cyc(4'h4, 1'b1, 1'b1, 16'h3C3C, '0);
        chk("count4", 16'h3C3C, channel_count_value[4]);
        chk("count0", CNT_RST, channel_count_value[0]);
        summarize();
    end
endmodule
